// File: hw/cstsel_pkg.sv
// cstsel_pkg: constants and carriers for the capture sync/trigger select
// assumes a 16-bit register map reached over classic wishbone, 32-bit data
package cstsel_pkg;
    // register byte offsets
    localparam logic [3:0] OFS_CONTROL_TWO = 4'h0;
    localparam logic [3:0] OFS_REMAP_5_6   = 4'h4;
    localparam logic [3:0] OFS_TIMER       = 4'h8;
    // control two fields
    localparam int SEL_LSB     = 0;
    localparam int TRIGMODE_BIT = 5;
    localparam int TRIGSTAT_BIT = 6;
    localparam int CASCADE_BIT = 8;
    // remap fields
    localparam int MAP5_LSB = 0;
    localparam int MAP6_LSB = 8;
    // reset values
    localparam logic [15:0] CONTROL_TWO_RST = 16'h0000;
    localparam logic [15:0] REMAP_RST       = 16'h0000;
    localparam logic [15:0] TIMER_RST       = 16'h0000;
    // selection codes
    localparam logic [4:0] SEL_OC_FIRST   = 5'h01;
    localparam logic [4:0] SEL_OC_LAST    = 5'h08;
    localparam logic [4:0] SEL_SEQ        = 5'h0a;
    localparam logic [4:0] SEL_GPT_FIRST  = 5'h0b;
    localparam logic [4:0] SEL_GPT_LAST   = 5'h0f;
    localparam logic [4:0] SEL_IC_FIRST   = 5'h10;
    localparam logic [4:0] SEL_IC_LAST    = 5'h17;
    localparam logic [4:0] SEL_CMP_FIRST  = 5'h18;
    localparam logic [4:0] SEL_CMP_LAST   = 5'h1a;
    localparam logic [4:0] SEL_ADC        = 5'h1b;
    localparam logic [4:0] SEL_CTU        = 5'h1c;
    // pin map codes
    localparam logic [6:0] MAP_GROUND = 7'h00;
    localparam logic [6:0] MAP_COMPARATOR1_OUT   = 7'h01;
    localparam logic [6:0] MAP_LAST   = 7'h7c;

    // on-chip event sources, one-cycle pulses
    typedef struct packed {
        logic [7:0] oc;
        logic [4:0] gpt;
        logic [7:0] ic_irq;
        logic [2:0] cmp;
        logic       adc_irq;
        logic       ctu_trig;
        logic [3:0] seq_out;
    } cstsel_src_t;

    // wishbone request
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } cstsel_wb_req_t;
endpackage

// File: hw/cstsel_top.sv
// cstsel_top: sync/trigger source select, trigger status, capture timer,
// pin remap for capture channels 5 and 6, cascade gate
// assumes event pulses are on clk_i; pins are asynchronous
//
// Summary of operation
// - a five-bit source select field sits in bits 4-0 of control two.
// - codes 11111, 11110, 11101, 01001 and 00000 attach no source.
// - code 11100 selects the charge-time unit trigger.
// - code 11011 selects the converter interrupt.
// - codes 11000-11010 select comparators 1-3.
// - codes 10000-10111 select capture channel 1-8 interrupts in order.
// - codes 01011-01111 select general timers 1-5 in order.
// - codes 00001-01000 select output compare channels 1-8 in order.
// - each channel has one sequencer input, outputs 8-11 to pairs 1/5-4/8.
// - cascade is active only when both channels of the pair enable it.
// - the selected event sets trigger status; software reads/sets/clears.
// - remap holds 7-bit maps, bits 14-8 channel 6 and bits 6-0 channel 5.
//
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module cstsel_top
    import cstsel_pkg::*;
#(
    parameter int CHANNEL = 1
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // event sources
    input  wire cstsel_src_t src_i,
    // pair partner cascade bit
    input  wire logic        partner_cascade_i,
    // remappable pins 2..124
    input  wire logic [124:0] pins_i,
    // results
    output logic             sync_event_o,
    output logic             trig_status_o,
    output logic             cascade_active_o,
    output logic             cascade_enable_o,
    output logic      [15:0] capture_timer_o,
    output logic             capture5_input_o,
    output logic             capture6_input_o
);

    logic [15:0]  ctrl;
    logic [15:0]  remap;
    logic [15:0]  timer;
    logic         ack;
    logic [124:0] pin_s1;
    logic [124:0] pin_s2;
    logic         in5;
    logic         in6;

    // source decode for one selection code
    function automatic logic pick(input logic [4:0] code,
                                  input cstsel_src_t s);
        logic hit;
        hit = 1'b0;
        if (code >= SEL_OC_FIRST && code <= SEL_OC_LAST) begin
            hit = s.oc[3'(code - SEL_OC_FIRST)];
        end else if (code == SEL_SEQ) begin
            hit = s.seq_out[2'((CHANNEL - 1) % 4)];
        end else if (code >= SEL_GPT_FIRST && code <= SEL_GPT_LAST) begin
            hit = s.gpt[3'(code - SEL_GPT_FIRST)];
        end else if (code >= SEL_IC_FIRST && code <= SEL_IC_LAST) begin
            hit = s.ic_irq[3'(code - SEL_IC_FIRST)];
        end else if (code >= SEL_CMP_FIRST && code <= SEL_CMP_LAST) begin
            hit = s.cmp[2'(code - SEL_CMP_FIRST)];
        end else if (code == SEL_ADC) begin
            hit = s.adc_irq;
        end else if (code == SEL_CTU) begin
            hit = s.ctu_trig;
        end
        return hit;
    endfunction

    // pin map decode, ground, comparator 1 or a pin
    function automatic logic map_pin(input logic [6:0] code,
                                     input logic comparator1_out,
                                     input logic [124:0] p);
        logic v;
        v = 1'b0;
        if (code == MAP_COMPARATOR1_OUT) begin
            v = comparator1_out;
        end else if (code != MAP_GROUND && code <= MAP_LAST) begin
            v = p[code];
        end
        return v;
    endfunction

    // bus decode
    wire        bus_go    = cyc_i && stb_i && !ack;
    wire        wr_go     = cyc_i && stb_i && ack && we_i &&
                            sel_i[0] && sel_i[1];
    wire        wr_ctrl   = wr_go && adr_i == OFS_CONTROL_TWO;
    wire        wr_remap  = wr_go && adr_i == OFS_REMAP_5_6;
    wire [4:0]  sel_code  = ctrl[SEL_LSB +: 5];
    wire        trig_mode = ctrl[TRIGMODE_BIT];
    // unsynchronized codes fall through to no hit
    wire        src_hit   = pick(sel_code, src_i);
    wire        casc_on   = ctrl[CASCADE_BIT] && partner_cascade_i;
    wire [15:0] remap_w   = {1'b0, dat_i[MAP6_LSB +: 7],
                             1'b0, dat_i[MAP5_LSB +: 7]};
    wire [15:0] ctrl_rd   = ctrl;
    wire [15:0] rd_mux    = adr_i == OFS_CONTROL_TWO ? ctrl_rd :
                            adr_i == OFS_REMAP_5_6   ? remap :
                            adr_i == OFS_TIMER       ? timer : 16'h0000;

    wire        stat_wr   = wr_ctrl ? dat_i[TRIGSTAT_BIT]
                                    : ctrl[TRIGSTAT_BIT];
    wire        next_stat = src_hit | stat_wr;
    wire [15:0] next_ctrl = wr_ctrl ? {dat_i[15:7], next_stat, dat_i[5:0]}
                                    : {ctrl[15:7], next_stat, ctrl[5:0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CONTROL_TWO_RST;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            remap <= REMAP_RST;
        end else if (wr_remap) begin
            remap <= remap_w;
        end
    end

    wire [15:0] next_timer = (src_hit && !trig_mode) ? TIMER_RST
                                                     : timer + 16'h0001;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer <= TIMER_RST;
        end else begin
            timer <= next_timer;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack   <= bus_go;
            dat_o <= {16'h0000, rd_mux};
        end
    end

    // pins pass two flip-flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= pins_i;
            pin_s2 <= pin_s1;
        end
    end

    // channel 5 and 6 input select
    assign in5 = map_pin(remap[MAP5_LSB +: 7], src_i.cmp[0], pin_s2);
    assign in6 = map_pin(remap[MAP6_LSB +: 7], src_i.cmp[0], pin_s2);

    assign ack_o            = ack;
    assign sync_event_o     = src_hit;
    assign trig_status_o    = ctrl[TRIGSTAT_BIT];
    assign cascade_active_o = casc_on;
    assign cascade_enable_o = ctrl[CASCADE_BIT];
    assign capture_timer_o  = timer;
    assign capture5_input_o = in5;
    assign capture6_input_o = in6;

    a_status_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        src_hit |=> trig_status_o)
        else $error("trigger status not set by event");
    a_timer_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        src_hit && !trig_mode |=> timer == 16'h0000)
        else $error("timer not cleared on sync");
    a_quiet_codes: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (sel_code == 5'h00 || sel_code == 5'h09 || sel_code >= 5'h1d)
        |-> !src_hit)
        else $error("unsynchronized code produced event");
    a_ctu_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h1c |-> src_hit == src_i.ctu_trig)
        else $error("charge unit routing wrong");
    a_adc_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h1b |-> src_hit == src_i.adc_irq)
        else $error("converter routing wrong");
    a_cmp_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h19 |-> src_hit == src_i.cmp[1])
        else $error("comparator routing wrong");
    a_comparator1_out_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h18 |-> src_hit == src_i.cmp[0])
        else $error("comparator 1 routing wrong");
    a_cmp3_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h1a |-> src_hit == src_i.cmp[2])
        else $error("comparator 3 routing wrong");
    a_ic_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h17 |-> src_hit == src_i.ic_irq[7])
        else $error("capture interrupt routing wrong");
    a_ic1_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h10 |-> src_hit == src_i.ic_irq[0])
        else $error("capture interrupt 1 routing wrong");
    a_gpt_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h0b |-> src_hit == src_i.gpt[0])
        else $error("general timer routing wrong");
    a_gpt5_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h0f |-> src_hit == src_i.gpt[4])
        else $error("general timer 5 routing wrong");
    a_oc_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h08 |-> src_hit == src_i.oc[7])
        else $error("compare routing wrong");
    a_oc1_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h01 |-> src_hit == src_i.oc[0])
        else $error("compare 1 routing wrong");
    a_seq_route: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_code == 5'h0a |-> src_hit == src_i.seq_out[(CHANNEL - 1) % 4])
        else $error("sequencer routing wrong");
    a_cascade_gate: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cascade_active_o |-> ctrl[CASCADE_BIT] && partner_cascade_i)
        else $error("cascade active without both halves");
    a_field_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl |=> sel_code == $past(dat_i[4:0]))
        else $error("select field not written");
    a_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_status_sw: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_ctrl && dat_i[TRIGSTAT_BIT] |=> trig_status_o)
        else $error("trigger status not set by software");
    a_status_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        trig_status_o && !src_hit && !wr_ctrl |=> trig_status_o)
        else $error("trigger status lost");
    a_timer_count: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !rst_i && !(src_hit && !trig_mode)
        |=> timer == $past(timer) + 16'h0001)
        else $error("timer did not count");
    a_map_ground: assert property (
        @(posedge clk_i) disable iff (rst_i)
        remap[6:0] == 7'h00 |-> !capture5_input_o)
        else $error("grounded input not low");
    a_map_comparator1_out: assert property (
        @(posedge clk_i) disable iff (rst_i)
        remap[MAP5_LSB +: 7] == 7'h01 |-> capture5_input_o == src_i.cmp[0])
        else $error("comparator 1 map wrong");
    a_map_pin: assert property (
        @(posedge clk_i) disable iff (rst_i)
        remap[MAP6_LSB +: 7] == 7'h7c |-> capture6_input_o == pin_s2[124])
        else $error("pin 124 map wrong");

    c_sync_event: cover property (@(posedge clk_i) disable iff (rst_i)
        src_hit && !trig_mode);
    c_trig_event: cover property (@(posedge clk_i) disable iff (rst_i)
        src_hit && trig_mode);
    c_cascade: cover property (@(posedge clk_i) disable iff (rst_i)
        cascade_active_o);
    c_remap_write: cover property (@(posedge clk_i) disable iff (rst_i)
        wr_remap);
endmodule

// File: tb/cstsel_src_model.sv
// cstsel_src_model: the on-chip event sources beside the capture channel
// assumes the bench asks for pulses as a one-hot word, one bit per source
`timescale 1ns/100ps
module cstsel_src_model
    import cstsel_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // pulse request, bit order as the source struct
    input  wire logic [29:0] fire_i,
    // event pulses
    output cstsel_src_t      src_o
);
    // sequencer outputs 8-11
    // one-cycle pulse per request, quiet otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_o <= '0;
        end else begin
            src_o <= cstsel_src_t'(fire_i);
        end
    end
endmodule

// File: tb/testbench.sv
// testbench: select codes, trigger status, timer clear, remap, cascade
// assumes channel 2, so sequencer output 9 and its own interrupt code 10001
`timescale 1ns/100ps
module testbench;
    import cstsel_pkg::*;
    logic           clk_i;
    logic           rst_i;
    cstsel_wb_req_t req;
    logic [31:0]    dat_o;
    logic           ack_o;
    cstsel_src_t    src;
    logic [29:0]    fire;
    logic           partner_cascade_i;
    logic [124:0]   pins_i;
    logic           sync_event_o;
    logic           trig_status_o;
    logic           cascade_active_o;
    logic           cascade_enable_o;
    logic [15:0]    capture_timer_o;
    logic           cap5;
    logic           cap6;
    logic [31:0]    rd;
    logic           seen;
    logic           trig;
    int             mismatches;
    int             num_checks;
    // expected source bit per select code, -1 for no source
    int rows [32] = '{-1, 22, 23, 24, 25, 26, 27, 28, 29, -1, 1, 17, 18, 19,
        20, 21, 9, 10, 11, 12, 13, 14, 15, 16, 6, 7, 8, 5, 4, -1, -1, -1};

    cstsel_top #(.CHANNEL(2)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb),
        .we_i(req.we), .sel_i(req.sel), .adr_i(req.adr), .dat_i(req.dat),
        .dat_o(dat_o), .ack_o(ack_o), .src_i(src),
        .partner_cascade_i(partner_cascade_i), .pins_i(pins_i),
        .sync_event_o(sync_event_o), .trig_status_o(trig_status_o),
        .cascade_active_o(cascade_active_o),
        .cascade_enable_o(cascade_enable_o),
        .capture_timer_o(capture_timer_o),
        .capture5_input_o(cap5), .capture6_input_o(cap6));
    cstsel_src_model i_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
        .src_o(src));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input string nm, input logic [31:0] got,
                         input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    // classic cycle: hold until ack is sampled high, then release
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, s, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (n >= 20) check("ack", 32'h0, 32'h1);
        q = dat_o;
        req <= '0;
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #500000;
        mismatches++;
        give_verdict();
    end

    initial begin
        req = '0;
        fire = '0;
        partner_cascade_i = 1'b0;
        pins_i = '0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, OFS_CONTROL_TWO, 32'h0, 4'hf, rd);
        check("control_two reset", rd, 32'(CONTROL_TWO_RST));
        wb(1'b0, OFS_REMAP_5_6, 32'h0, 4'hf, rd);
        check("remap reset", rd, 32'(REMAP_RST));
        wb(1'b1, 4'hc, 32'h1234, 4'hf, rd);
        wb(1'b0, 4'hc, 32'h0, 4'hf, rd);
        check("unmapped read", rd, 32'h0);
        wb(1'b1, OFS_CONTROL_TWO, 32'h1f, 4'h0, rd);
        wb(1'b0, OFS_CONTROL_TWO, 32'h0, 4'hf, rd);
        check("no byte enable", rd, 32'h0);
        wb(1'b1, OFS_CONTROL_TWO, 32'h13, 4'hf, rd);
        wb(1'b0, OFS_CONTROL_TWO, 32'h0, 4'hf, rd);
        check("select field", rd, 32'h13);
        wb(1'b1, OFS_CONTROL_TWO, 32'h40, 4'hf, rd);
        #1 check("status set", trig_status_o, 32'h1);
        wb(1'b1, OFS_CONTROL_TWO, 32'h100, 4'hf, rd);
        #1 check("status clear", trig_status_o, 32'h0);
        check("cascade alone", cascade_active_o, 32'h0);
        check("cascade own bit", cascade_enable_o, 32'h1);
        @(posedge clk_i);
        partner_cascade_i <= 1'b1;
        @(posedge clk_i);
        #1 check("cascade pair", cascade_active_o, 32'h1);
        wb(1'b1, OFS_REMAP_5_6, 32'h7c02, 4'hf, rd);
        pins_i <= '1;
        repeat (4) @(posedge clk_i);
        #1 check("pin map 6", cap6, 32'h1);
        check("pin map 5", cap5, 32'h1);
        wb(1'b1, OFS_REMAP_5_6, 32'h0002, 4'hf, rd);
        #1 check("map ground", cap6, 32'h0);
        for (int c = 0; c < 32; c++) begin
            // code 10001 selects channel 2's own interrupt; the sweep skips it
            if (c == 17) continue;
            // comparator and converter codes only in trigger mode
            trig = (c >= 24 && c <= 27);
            wb(1'b1, OFS_CONTROL_TWO, 32'(c) | {26'h0, trig, 5'h0}, 4'hf, rd);
            seen = 1'b0;
            for (int b = 0; b < 30; b++) begin
                @(posedge clk_i);
                fire <= 30'h1 << b;
                @(posedge clk_i);
                fire <= '0;
                #1 check("sync event", sync_event_o, b == rows[c]);
                if (b == rows[c]) seen = 1'b1;
                @(posedge clk_i);
                #1 check("trigger status", trig_status_o, seen);
                if (b == rows[c] && !trig) check("timer", capture_timer_o, 32'h0);
            end
        end
        // comparator 1 on channel 5, channel 6 grounded
        wb(1'b1, OFS_REMAP_5_6, 32'h0001, 4'hf, rd);
        fire <= 30'h40;
        @(posedge clk_i);
        fire <= '0;
        #1 check("map comparator", cap5, 32'h1);
        check("map ground 6", cap6, 32'h0);
        // reset in mid-run, timer restarts from the first edge after it
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, OFS_TIMER, 32'h0, 4'hf, rd);
        check("timer restart", rd, 32'h1);
        wb(1'b0, OFS_CONTROL_TWO, 32'h0, 4'hf, rd);
        check("control_two rerun", rd, 32'(CONTROL_TWO_RST));
        wb(1'b0, OFS_REMAP_5_6, 32'h0, 4'hf, rd);
        check("remap rerun", rd, 32'(REMAP_RST));
        check("status rerun", trig_status_o, 32'h0);
        give_verdict();
    end
endmodule
